// ---- core/cmg_bcd.sv ----
// Sixteen-bit step unit: binary or four-digit BCD, up or down.
// Pure combinational; used by the counter core.
`timescale 1ns/100ps
`default_nettype none
module cmg_bcd (
    input  wire logic [15:0] val,   // Present count
    input  wire logic        up,    // Count up
    input  wire logic        bcd,   // BCD radix
    output logic      [15:0] res    // Stepped count
);
    logic c;
    always_comb begin
        res = val;
        c   = 1'b1;
        if (!bcd) begin
            res = up ? val + 16'h0001 : val - 16'h0001;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (c) begin
                    if (up) begin
                        c = (val[i*4 +: 4] == 4'h9);
                        res[i*4 +: 4] = c ? 4'h0 : val[i*4 +: 4] + 4'h1;
                    end else begin
                        c = (val[i*4 +: 4] == 4'h0);
                        res[i*4 +: 4] = c ? 4'h9 : val[i*4 +: 4] - 4'h1;
                    end
                end
            end
        end
    end
endmodule : cmg_bcd
`default_nettype wire

// ---- core/cmg_counter.sv ----
// One general counter: mode word, source select, gating, reload, retrigger.
// Assumes an APB master on pclk; pins and neighbour signals are asynchronous.
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/100ps
`default_nettype none
module cmg_counter (
    input  wire logic        pclk,        // Clock, 125 MHz
    input  wire logic        presetn,     // Async reset, low
    input  wire logic        psel,        // APB select
    input  wire logic        penable,     // APB enable
    input  wire logic        pwrite,      // APB write
    input  wire logic [11:0] paddr,       // APB byte address
    input  wire logic [31:0] pwdata,      // APB write data
    output logic      [31:0] prdata,      // APB read data
    output logic             pready,      // APB ready
    output logic             pslverr,     // APB error
    input  wire logic [4:0]  freq_in,     // Scaled oscillator taps
    input  wire logic [4:0]  count_source_pin, // Source pins 1..5
    input  wire logic [4:0]  gate_pins,   // Gate pins 1..5
    input  wire logic [2:0]  counter_idx, // This counter, 0..4
    input  wire logic        lower_neighbour_terminal_count, // Lower TC
    output logic             terminal_count // TC level
);
    typedef enum logic [1:0] {ST_IDLE, ST_WAIT_EDGE, ST_RUN} cmg_run_t;
    typedef struct packed {
        logic [15:0] mode;
        logic [15:0] load;
        logic [15:0] hold;
        logic [15:0] count;
        logic        armed;
        logic        tc;
        logic        in_tc;
        logic        pend_retrig;
        logic        alt_hold;
        logic        tc_seen;
        logic        src_d;
        logic        gate_d;
        cmg_run_t    run;
        logic [31:0] rdata;
    } cmg_state_t;

    cmg_state_t  st_r;
    cmg_state_t  st_nxt;
    cmg_sync_if  sif ();
    logic [15:0] step_val;

    function automatic logic reg_hit(input logic [11:0] a, input logic [11:0] o);
        reg_hit = (a == o);
    endfunction : reg_hit

    function automatic logic [2:0] wrap5(input logic [2:0] i, input logic up);
        if (up) begin
            wrap5 = (i == 3'h4) ? 3'h0 : i + 3'h1;
        end else begin
            wrap5 = (i == 3'h0) ? 3'h4 : i - 3'h1;
        end
    endfunction : wrap5

    // All outside levels pass the two-flop bank before any use
    assign sif.raw = {lower_neighbour_terminal_count, gate_pins, count_source_pin, freq_in};
    cmg_sync u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .sif     (sif)
    );

    logic [4:0]  s_freq;
    logic [4:0]  s_src;
    logic [4:0]  s_gate;
    logic        s_tcl;
    logic [15:0] srcs;
    logic        src_lvl;
    logic        gate_lvl;
    logic        gate_own;
    logic [2:0]  gcode;
    logic        src_edge;
    logic        gate_edge;
    logic        gated_on;
    logic        qual;
    logic        at_last;
    logic        retrig_en;
    logic        edge_mode;
    logic        wr;
    logic        rd;
    logic        known;
    logic [3:0]  cmd;

    assign s_freq   = sif.synced[4:0];
    assign s_src    = sif.synced[9:5];
    assign s_gate   = sif.synced[14:10];
    assign s_tcl    = sif.synced[15];
    localparam int SRC_SEL_HI = cmg_pkg::SRC_LSB + 3;
    assign srcs     = {s_tcl, s_gate, s_src, s_freq};
    // Polarity inverts the chosen source so one rising detector serves both
    assign src_lvl  = srcs[st_r.mode[SRC_SEL_HI:cmg_pkg::SRC_LSB]]
                      ^ st_r.mode[cmg_pkg::BIT_POL];
    assign gcode    = st_r.mode[15:cmg_pkg::GATE_LSB];
    assign gate_own = s_gate[counter_idx];
    assign edge_mode = gcode[2] & gcode[1];

    always_comb begin
        case (gcode)
            cmg_pkg::G_NONE:     gate_lvl = 1'b1;
            cmg_pkg::G_TC_LOWER: gate_lvl = s_tcl;
            cmg_pkg::G_HIGHER:   gate_lvl = s_gate[wrap5(counter_idx, 1'b1)];
            cmg_pkg::G_LOWER:    gate_lvl = s_gate[wrap5(counter_idx, 1'b0)];
            cmg_pkg::G_OWN_HI:   gate_lvl = gate_own;
            cmg_pkg::G_OWN_LO:   gate_lvl = ~gate_own;
            cmg_pkg::G_EDGE_HI:  gate_lvl = gate_own;
            cmg_pkg::G_EDGE_LO:  gate_lvl = ~gate_own;
            default:             gate_lvl = 1'b0;
        endcase
    end

    assign src_edge  = src_lvl & ~st_r.src_d;
    assign gate_edge = gate_lvl & ~st_r.gate_d & (gcode != cmg_pkg::G_NONE);
    // Level gate is looked at only on the source edge itself
    assign gated_on  = edge_mode ? (st_r.run == ST_RUN) : gate_lvl;
    assign qual      = src_edge & st_r.armed & gated_on;
    assign retrig_en = (gcode != cmg_pkg::G_NONE) & st_r.mode[cmg_pkg::BIT_SPECIAL];
    assign at_last   = st_r.mode[cmg_pkg::BIT_DIR]
                       ? (st_r.count == (st_r.mode[cmg_pkg::BIT_RADIX] ? cmg_pkg::BCD_TOP
                                                                      : cmg_pkg::BIN_TOP))
                       : (st_r.count == cmg_pkg::DOWN_LAST);

    cmg_bcd u_step (
        .val (st_r.count),
        .up  (st_r.mode[cmg_pkg::BIT_DIR]),
        .bcd (st_r.mode[cmg_pkg::BIT_RADIX]),
        .res (step_val)
    );

    assign wr  = psel & penable & pwrite;
    assign rd  = psel & ~penable & ~pwrite;
    assign known = reg_hit(paddr, cmg_pkg::OFF_MODE) | reg_hit(paddr, cmg_pkg::OFF_LOAD)
                 | reg_hit(paddr, cmg_pkg::OFF_HOLD) | reg_hit(paddr, cmg_pkg::OFF_CMD)
                 | reg_hit(paddr, cmg_pkg::OFF_COUNT) | reg_hit(paddr, cmg_pkg::OFF_STATUS);
    assign cmd = (wr & reg_hit(paddr, cmg_pkg::OFF_CMD)) ? pwdata[3:0] : 4'h0;

    logic cnt_ev;
    logic use_hold;
    always_comb begin
        st_nxt       = st_r;
        st_nxt.src_d = src_lvl;
        st_nxt.gate_d = gate_lvl;
        cnt_ev       = 1'b0;
        // Reload choice for a terminal count taken this cycle
        if (!st_r.mode[cmg_pkg::BIT_RELOAD]) begin
            use_hold = 1'b0;
        end else if (gcode == cmg_pkg::G_NONE && st_r.mode[cmg_pkg::BIT_SPECIAL]) begin
            use_hold = gate_own;
        end else begin
            use_hold = st_r.alt_hold;
        end
        if (wr && reg_hit(paddr, cmg_pkg::OFF_MODE)) st_nxt.mode = pwdata[15:0];
        if (wr && reg_hit(paddr, cmg_pkg::OFF_LOAD)) st_nxt.load = pwdata[15:0];
        if (wr && reg_hit(paddr, cmg_pkg::OFF_HOLD)) st_nxt.hold = pwdata[15:0];
        if (cmd[cmg_pkg::CMD_ARM]) begin
            st_nxt.armed    = 1'b1;
            st_nxt.alt_hold = 1'b1;
            st_nxt.run      = edge_mode ? ST_WAIT_EDGE : ST_RUN;
        end
        // Disarm is dropped while TC is high so it cannot latch up there
        if (cmd[cmg_pkg::CMD_DISARM] && !st_r.tc) st_nxt.armed = 1'b0;
        // Edge gating: start edge, and a later edge once past TC when repeating
        if (edge_mode && gate_edge && st_r.armed
            && (st_r.run == ST_WAIT_EDGE
                || (st_r.mode[cmg_pkg::BIT_REPEAT] && st_r.tc_seen))) begin
            st_nxt.run     = ST_RUN;
            st_nxt.tc_seen = 1'b0;
        end
        // Inside the terminal-count interval any source edge counts
        cnt_ev = qual | cmd[cmg_pkg::CMD_STEP] | (st_r.in_tc & src_edge);
        if (cmd[cmg_pkg::CMD_LOAD] && !st_r.pend_retrig) begin
            st_nxt.count = st_r.load;
            cnt_ev       = 1'b0;
        end
        st_nxt.tc = 1'b0;
        if (cnt_ev || cmd[cmg_pkg::CMD_LOAD]) st_nxt.in_tc = 1'b0;
        if ((cnt_ev || cmd[cmg_pkg::CMD_LOAD]) && st_r.pend_retrig) begin
            st_nxt.count       = st_r.load;
            st_nxt.pend_retrig = 1'b0;
        end else if (cnt_ev) begin
            if (at_last) begin
                st_nxt.count    = use_hold ? st_r.hold : st_r.load;
                st_nxt.tc       = 1'b1;
                st_nxt.in_tc    = 1'b1;
                st_nxt.alt_hold = ~st_r.alt_hold;
                st_nxt.tc_seen  = 1'b1;
                if (edge_mode) begin
                    st_nxt.run = ST_WAIT_EDGE;
                end
                // Single cycle ends after one TC, or two when alternating with a gate code other than G_NONE
                if (!st_r.mode[cmg_pkg::BIT_REPEAT]
                    && (!st_r.mode[cmg_pkg::BIT_RELOAD] || !st_r.alt_hold
                        || gcode == cmg_pkg::G_NONE)) begin
                    st_nxt.armed = 1'b0;
                end
            end else begin
                st_nxt.count = step_val;
            end
        end
        // Retrigger last, so a fresh gate edge beats the pending clear
        if (retrig_en && gate_edge && st_r.armed && !at_last) begin
            st_nxt.hold        = st_r.count;
            st_nxt.pend_retrig = 1'b1;
        end
        st_nxt.rdata = st_r.rdata;
        if (rd) begin
            if (reg_hit(paddr, cmg_pkg::OFF_MODE))   st_nxt.rdata = {16'h0000, st_r.mode};
            else if (reg_hit(paddr, cmg_pkg::OFF_LOAD))  st_nxt.rdata = {16'h0000, st_r.load};
            else if (reg_hit(paddr, cmg_pkg::OFF_HOLD))  st_nxt.rdata = {16'h0000, st_r.hold};
            else if (reg_hit(paddr, cmg_pkg::OFF_COUNT)) st_nxt.rdata = {16'h0000, st_r.count};
            else if (reg_hit(paddr, cmg_pkg::OFF_STATUS)) begin
                st_nxt.rdata = {27'h0000000, st_r.run == ST_RUN, st_r.tc_seen,
                                st_r.pend_retrig, st_r.tc, st_r.armed};
            end else begin
                st_nxt.rdata = 32'h00000000;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r      <= '0;
            st_r.mode <= cmg_pkg::MODE_RESET;
            st_r.run  <= ST_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prdata         = st_r.rdata;
    assign pready         = 1'b1;
    assign pslverr        = psel & penable & ~known;
    assign terminal_count = st_r.tc;

    a_tc_reload: assert property (@(posedge pclk) disable iff (!presetn)
        (cnt_ev && at_last && !st_r.pend_retrig && !st_r.mode[cmg_pkg::BIT_RELOAD])
        |=> (st_r.count == $past(st_r.load)) && st_r.tc)
        else $error("reload from load missing");
    a_tc_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
        (st_r.tc && !(cnt_ev && at_last)) |=> !st_r.tc)
        else $error("tc held too long");
    a_retrig_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (retrig_en && gate_edge && st_r.armed && !at_last) |=> st_r.pend_retrig
        && st_r.hold == $past(st_r.count))
        else $error("retrigger did not save count");
    sequence s_pend_edge;
        st_r.pend_retrig && qual && !gate_edge;
    endsequence
    a_retrig_load: assert property (@(posedge pclk) disable iff (!presetn)
        s_pend_edge |=> st_r.count == $past(st_r.load) && !st_r.pend_retrig)
        else $error("first edge did not load");
    a_qual_needs: assert property (@(posedge pclk) disable iff (!presetn)
        qual |-> st_r.armed && gated_on)
        else $error("unqualified edge counted");
    a_idle_count: assert property (@(posedge pclk) disable iff (!presetn)
        (!st_r.armed && !st_r.in_tc && !cmd[cmg_pkg::CMD_STEP] && !cmd[cmg_pkg::CMD_LOAD]
         && !wr) |=> st_r.count == $past(st_r.count))
        else $error("disarmed counter moved");
    a_single_disarm: assert property (@(posedge pclk) disable iff (!presetn)
        (cnt_ev && at_last && !st_r.pend_retrig && !st_r.mode[cmg_pkg::BIT_REPEAT]
         && !st_r.mode[cmg_pkg::BIT_RELOAD] && !cmd[cmg_pkg::CMD_ARM]) |=> !st_r.armed)
        else $error("single cycle not disarmed");
    a_repeat_armed: assert property (@(posedge pclk) disable iff (!presetn)
        (st_r.armed && st_r.mode[cmg_pkg::BIT_REPEAT] && !cmd[cmg_pkg::CMD_DISARM])
        |=> st_r.armed)
        else $error("repeat counter disarmed");
    a_edge_start: assert property (@(posedge pclk) disable iff (!presetn)
        (edge_mode && st_r.run == ST_WAIT_EDGE && gate_edge && st_r.armed
         && !(cnt_ev && at_last)) |=> st_r.run == ST_RUN)
        else $error("edge gate did not start");

    // Terminal count taken this cycle, shared by the alternating and gate-selected reload checks
    sequence s_tc_take;
        cnt_ev && at_last && !st_r.pend_retrig;
    endsequence

    a_trail_count: assert property (@(posedge pclk) disable iff (!presetn)
        (st_r.in_tc && src_edge && !st_r.armed && !st_r.pend_retrig && !at_last
         && cmd == 4'h0) |=> st_r.count == $past(step_val))
        else $error("trailing edge not counted");

    a_step_retrig: assert property (@(posedge pclk) disable iff (!presetn)
        (cmd[cmg_pkg::CMD_STEP] && st_r.pend_retrig && !gate_edge)
        |=> st_r.count == $past(st_r.load) && !st_r.pend_retrig)
        else $error("step after retrigger did not load");

    // Level gate closed: a source edge alone must not move the count
    a_gated_off: assert property (@(posedge pclk) disable iff (!presetn)
        (src_edge && !edge_mode && !gate_lvl && !st_r.in_tc && cmd == 4'h0 && !wr)
        |=> st_r.count == $past(st_r.count))
        else $error("edge counted while gated off");

    // Once started, edge gating counts whatever the gate does
    a_edge_run: assert property (@(posedge pclk) disable iff (!presetn)
        (edge_mode && st_r.run == ST_RUN && st_r.armed && src_edge && !st_r.pend_retrig
         && !at_last && cmd == 4'h0) |=> st_r.count == $past(step_val))
        else $error("running edge gate lost a count");

    a_alt_reload: assert property (@(posedge pclk) disable iff (!presetn)
        (s_tc_take ##0 (st_r.mode[cmg_pkg::BIT_RELOAD] && !st_r.mode[cmg_pkg::BIT_SPECIAL]))
        |=> st_r.count == ($past(st_r.alt_hold) ? $past(st_r.hold) : $past(st_r.load)))
        else $error("alternating reload wrong");

    a_gate_reload: assert property (@(posedge pclk) disable iff (!presetn)
        (s_tc_take ##0 (st_r.mode[cmg_pkg::BIT_RELOAD] && st_r.mode[cmg_pkg::BIT_SPECIAL]
                        && gcode == cmg_pkg::G_NONE))
        |=> st_r.count == ($past(gate_own) ? $past(st_r.hold) : $past(st_r.load)))
        else $error("gate-selected reload wrong");

    a_arm_cmd: assert property (@(posedge pclk) disable iff (!presetn)
        (cmd[cmg_pkg::CMD_ARM] && !cmd[cmg_pkg::CMD_DISARM] && !(cnt_ev && at_last))
        |=> st_r.armed)
        else $error("arm command ignored");
endmodule : cmg_counter
`default_nettype wire

// ---- core/cmg_pkg.sv ----
// Shared constants for the counter mode, count and gating block.
// Assumes a 32-bit APB register bus and a single pclk domain.
package cmg_pkg;
    localparam logic [11:0] OFF_MODE     = 12'h000;
    localparam logic [11:0] OFF_LOAD     = 12'h004;
    localparam logic [11:0] OFF_HOLD     = 12'h008;
    localparam logic [11:0] OFF_CMD      = 12'h00C;
    localparam logic [11:0] OFF_COUNT    = 12'h010;
    localparam logic [11:0] OFF_STATUS   = 12'h014;
    localparam int          BIT_DIR      = 3;
    localparam int          BIT_RADIX    = 4;
    localparam int          BIT_REPEAT   = 5;
    localparam int          BIT_RELOAD   = 6;
    localparam int          BIT_SPECIAL  = 7;
    localparam int          SRC_LSB      = 8;
    localparam int          BIT_POL      = 12;
    localparam int          GATE_LSB     = 13;
    localparam logic [15:0] MODE_RESET   = 16'h0B00;
    localparam int          CMD_LOAD     = 0;
    localparam int          CMD_ARM      = 1;
    localparam int          CMD_DISARM   = 2;
    localparam int          CMD_STEP     = 3;
    localparam logic [2:0]  G_NONE       = 3'h0;
    localparam logic [2:0]  G_TC_LOWER   = 3'h1;
    localparam logic [2:0]  G_HIGHER     = 3'h2;
    localparam logic [2:0]  G_LOWER      = 3'h3;
    localparam logic [2:0]  G_OWN_HI     = 3'h4;
    localparam logic [2:0]  G_OWN_LO     = 3'h5;
    localparam logic [2:0]  G_EDGE_HI    = 3'h6;
    localparam logic [2:0]  G_EDGE_LO    = 3'h7;
    localparam logic [15:0] BCD_TOP      = 16'h9999;
    localparam logic [15:0] BIN_TOP      = 16'hFFFF;
    localparam logic [15:0] DOWN_LAST    = 16'h0001;
endpackage : cmg_pkg

// ---- core/cmg_sync.sv ----
// Two-flop synchroniser bank for the sixteen count and gate inputs.
// Assumes inputs are asynchronous to pclk.
`timescale 1ns/100ps
`default_nettype none
module cmg_sync (
    input wire logic    pclk,    // Clock
    input wire logic    presetn, // Async reset, low
    cmg_sync_if.samp    sif      // Raw in, synced out
);
    typedef struct packed {
        logic [15:0] s1;
        logic [15:0] s2;
    } cmg_sync_t;
    cmg_sync_t st_r;
    cmg_sync_t st_nxt;
    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = sif.raw;
        st_nxt.s2 = st_r.s1;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign sif.synced = st_r.s2;
endmodule : cmg_sync
`default_nettype wire

// ---- core/cmg_sync_if.sv ----
// Carrier for synchronised external levels between the top and its sampler.
// Assumes both ends run on pclk.
`timescale 1ns/100ps
`default_nettype none
interface cmg_sync_if;
    logic [15:0] raw;
    logic [15:0] synced;
    modport samp (input raw, output synced);
    modport user (output raw, input synced);
endinterface : cmg_sync_if
`default_nettype wire

// ---- verif/cmg_pin_model.sv ----
// Far side model: oscillator taps, source pins, gate pins and lower TC line.
// Assumes one bench process calls its tasks, each starting on a pclk edge.
`timescale 1ns/100ps
`default_nettype none
module cmg_pin_model (
    input  wire logic        pclk,  // Clock
    output var  logic [15:0] lines  // Lines in source index order
);
    initial lines = 16'h0000;
    // Levels held well past the sync and edge-detect delay
    task automatic set_level(input int idx, input logic v);
        @(posedge pclk);
        lines[idx] <= v;
        repeat (6) @(posedge pclk);
    endtask : set_level
    task automatic pulse(input int idx);
        set_level(idx, 1'b1);
        set_level(idx, 1'b0);
    endtask : pulse
endmodule : cmg_pin_model
`default_nettype wire

// ---- verif/tb_counter_mode_count_gating_control.sv ----
// Self-checking bench: APB master, random loads, pin stimulus through the model.
// Gating pass draws the counter index at random, so neighbour links wrap.
`timescale 1ns/100ps
`default_nettype none
module tb_counter_mode_count_gating_control;
    localparam logic [11:0] A_CNT = cmg_pkg::OFF_COUNT;
    localparam logic [11:0] A_CMD = cmg_pkg::OFF_CMD;
    localparam logic [11:0] A_HLD = cmg_pkg::OFF_HOLD;
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h00000000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        tc;
    logic [15:0] lines;
    logic [2:0]  cidx    = 3'h4;
    logic [31:0] seed    = 32'h00000049;
    logic [31:0] q;
    logic        e;
    int          n_mismatch   = 0;
    int          total_checks = 0;
    int          n_tc         = 0;
    int          cycles       = 0;
    int          gcode[8]     = '{0, 4, 5, 2, 3, 1, 6, 7};

    always #4 pclk = ~pclk;

    cmg_counter cmg_counter_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .freq_in(lines[4:0]),
        .count_source_pin(lines[9:5]), .gate_pins(lines[14:10]),
        .counter_idx(cidx), .lower_neighbour_terminal_count(lines[15]),
        .terminal_count(tc)
    );
    cmg_pin_model cmg_pin_model_i (.pclk(pclk), .lines(lines));

    task automatic wrap_up();
        $display("Checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : wrap_up

    // Hang guard well above the some 1,740 cycles the run needs
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch = n_mismatch + 1;
            wrap_up();
        end
    end

    // Counted mid-cycle so the launching edge cannot race the count
    always @(negedge pclk) begin
        if (tc === 1'b1) n_tc <= n_tc + 1;
    end

    // Gate line each gating code watches, neighbours wrapping 4 <-> 0
    function automatic int gpin(input int g, input int k);
        case (g)
            1:       return 15;
            2:       return 10 + ((k == 4) ? 0 : k + 1);
            3:       return 10 + ((k == 0) ? 4 : k - 1);
            default: return 10 + k;
        endcase
    endfunction : gpin

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        chk(q, exp);
    endtask : rd_chk

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    function automatic logic [15:0] mk(input logic [2:0] g, input logic [3:0] s,
                                       input logic pol, sp, rep, up, bcd);
        logic [15:0] m;
        m = 16'h0000;
        m[cmg_pkg::GATE_LSB+:3] = g;
        m[cmg_pkg::SRC_LSB+:4]  = s;
        m[cmg_pkg::BIT_POL]     = pol;
        m[cmg_pkg::BIT_SPECIAL] = sp;
        m[cmg_pkg::BIT_REPEAT]  = rep;
        m[cmg_pkg::BIT_DIR]     = up;
        m[cmg_pkg::BIT_RADIX]   = bcd;
        return m;
    endfunction : mk

    function automatic logic [15:0] nstep(input logic [15:0] v, input logic up, bcd);
        logic [15:0] r;
        logic        c;
        if (!bcd) return up ? v + 16'h0001 : v - 16'h0001;
        r = v;
        c = 1'b1;
        for (int i = 0; i < 4; i++) begin
            if (c && up && r[i*4+:4] == 4'h9) r[i*4+:4] = 4'h0;
            else if (c && !up && r[i*4+:4] == 4'h0) r[i*4+:4] = 4'h9;
            else if (c) begin
                r[i*4+:4] = up ? r[i*4+:4] + 4'h1 : r[i*4+:4] - 4'h1;
                c = 1'b0;
            end
        end
        return r;
    endfunction : nstep

    // Mode is only written while disarmed; armed writes are erratic
    task automatic setup(input logic [15:0] m, input logic [15:0] ld);
        apb(1'b1, A_CMD, 32'h00000004);
        apb(1'b1, cmg_pkg::OFF_MODE, {16'h0000, m});
        apb(1'b1, cmg_pkg::OFF_LOAD, {16'h0000, ld});
        apb(1'b1, A_CMD, 32'h00000003);
    endtask : setup

    initial begin
        logic [15:0] ld;
        logic        act;
        int          c;
        int          gl;
        int          k;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(cmg_pkg::OFF_MODE, {16'h0000, cmg_pkg::MODE_RESET});
        rd_chk(A_CNT, 32'h00000000);
        apb(1'b1, 12'h040, 32'hFFFFFFFF);
        chk({31'h0, e}, 32'h00000001);
        rd_chk(12'h040, 32'h00000000);
        for (int r = 0; r < 2; r++) begin
            setup(mk(3'h0, 4'h5, 1'b0, 1'b0, r[0], 1'b0, 1'b0), 16'h0003);
            c = n_tc;
            repeat (3) cmg_pin_model_i.pulse(5);
            rd_chk(A_CNT, 32'h00000003);
            chk(n_tc - c, 32'h00000001);
            repeat (2) cmg_pin_model_i.pulse(5);
            rd_chk(A_CNT, r ? 32'h00000001 : 32'h00000002);
            apb(1'b0, cmg_pkg::OFF_STATUS, 32'h00000000);
            chk({31'h0, q[0]}, r);
        end
        for (int i = 0; i < 4; i++) begin
            ld = {4'(1 + rnd() % 8), 4'(rnd() % 10), 4'(rnd() % 10), 4'(rnd() % 10)};
            setup(mk(3'h0, 4'h5, 1'b0, 1'b0, 1'b1, i[0], i[1]), ld);
            repeat (2) cmg_pin_model_i.pulse(5);
            rd_chk(A_CNT, {16'h0000, nstep(nstep(ld, i[0], i[1]), i[0], i[1])});
        end
        for (int i = 0; i < 16; i++) begin
            ld = 16'(rnd());
            setup(mk(3'h0, 4'(i), ld[0], 1'b0, 1'b1, 1'b0, 1'b0), 16'h0200);
            cmg_pin_model_i.set_level(i, 1'b1);
            rd_chk(A_CNT, ld[0] ? 32'h00000200 : 32'h000001FF);
            cmg_pin_model_i.set_level(i, 1'b0);
            rd_chk(A_CNT, 32'h000001FF);
        end
        for (int i = 0; i < 8; i++) begin
            c    = gcode[i];
            k    = int'(rnd() % 5);
            gl   = gpin(c, k);
            cidx <= 3'(k);
            act = (c == 5 || c == 7) ? 1'b0 : 1'b1;
            cmg_pin_model_i.set_level(gl, !act);
            setup(mk(3'(c), 4'h5, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0), 16'h0100);
            cmg_pin_model_i.pulse(5);
            rd_chk(A_CNT, c == 0 ? 32'h000000FF : 32'h00000100);
            cmg_pin_model_i.set_level(gl, act);
            if (c >= 6) cmg_pin_model_i.set_level(gl, !act);
            cmg_pin_model_i.pulse(5);
            rd_chk(A_CNT, c == 0 ? 32'h000000FE : 32'h000000FF);
            cmg_pin_model_i.set_level(gl, 1'b0);
        end
        cidx <= 3'h4;
        apb(1'b1, A_CMD, 32'h00000004);
        cmg_pin_model_i.pulse(5);
        rd_chk(A_CNT, 32'h000000FF);
        for (int i = 0; i < 2; i++) begin
            setup(mk(3'h4, 4'h5, 1'b0, i[0], 1'b1, 1'b0, 1'b0), 16'h0050);
            apb(1'b1, A_HLD, 32'h00001234);
            cmg_pin_model_i.set_level(14, 1'b1);
            repeat (3) cmg_pin_model_i.pulse(5);
            rd_chk(A_CNT, i ? 32'h0000004E : 32'h0000004D);
            rd_chk(A_HLD, i ? 32'h00000050 : 32'h00001234);
            if (i == 1) begin
                cmg_pin_model_i.set_level(14, 1'b0);
                cmg_pin_model_i.set_level(14, 1'b1);
                rd_chk(A_HLD, 32'h0000004E);
                apb(1'b1, A_CMD, 32'h00000008);
                rd_chk(A_CNT, 32'h00000050);
                cmg_pin_model_i.pulse(5);
                rd_chk(A_CNT, 32'h0000004F);
            end
            cmg_pin_model_i.set_level(14, 1'b0);
        end
        // Reload from hold: first count after arming, then gate-selected
        for (int i = 0; i < 2; i++) begin
            setup(mk(3'h0, 4'h5, 1'b0, i[0], 1'b1, 1'b0, 1'b0)
                  | 16'(1 << cmg_pkg::BIT_RELOAD), 16'h0001);
            apb(1'b1, A_HLD, 32'h00000007);
            cmg_pin_model_i.set_level(14, i[0]);
            cmg_pin_model_i.pulse(5);
            rd_chk(A_CNT, 32'h00000007);
            cmg_pin_model_i.set_level(14, 1'b0);
        end
        wrap_up();
    end
endmodule : tb_counter_mode_count_gating_control
`default_nettype wire
